/* File: sadc_pkg.sv */
// Shared constants and types for the serial converter link
package sadc_pkg;
  localparam int unsigned SADC_RES_BITS   = 8;
  localparam int unsigned SADC_CMD_BITS   = 3;
  localparam int unsigned SADC_FIFO_DEPTH = 16;
  localparam int unsigned SADC_CLK_HZ     = 40000000;
  localparam int unsigned SADC_SCLK_HZ    = 250000;
  // System cycles per half serial clock period
  localparam int unsigned SADC_HALF_CYC   = SADC_CLK_HZ / (2 * SADC_SCLK_HZ);
  localparam logic [7:0]  SADC_HALF_CNT   = SADC_HALF_CYC[7:0];
  // Command layout: start, mode select, channel/polarity
  localparam int unsigned SADC_CMD_START  = 2;
  localparam int unsigned SADC_CMD_MODE   = 1;
  localparam int unsigned SADC_CMD_ODD    = 0;
  localparam logic [7:0]  SADC_RES_RST    = 8'h00;
  localparam logic [7:0]  SADC_SAR_MSB    = 8'h80;
  typedef enum logic {SADC_FIXED, SADC_MUXED} sadc_variant_t;
endpackage

/* File: sadc_if.sv */
// Serial pins between host and converter
`timescale 1ns/10ps
interface sadc_if;
  logic sel_n;
  logic sclk;
  logic cmd_out;
  logic cmd_oe;
  logic dout;
  logic dout_oe;
  // Resolved level of shared serial line (pull-up when idle)
  logic line;
  assign line = dout_oe ? dout : (cmd_oe ? cmd_out : 1'b1);
  modport device (input sel_n, input sclk, input line,
                  output dout, output dout_oe);
  modport host (output sel_n, output sclk, output cmd_out,
                output cmd_oe, input line);
endinterface

/* File: sadc_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module sadc_fifo
  import sadc_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Handshake terms
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // Storage write
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* File: sadc_device.sv */
// Converter end: command intake, approximation and serial result
`timescale 1ns/10ps
module sadc_device
  import sadc_pkg::*;
#(
  parameter sadc_variant_t VARIANT = SADC_MUXED
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  sadc_if.device          pins,
  input  wire logic [7:0] analog_in_a,
  input  wire logic [7:0] analog_in_b,
  output logic            single_or_diff_sel,
  output logic            busy
);
  typedef enum {SADC_IDLE, SADC_CMD, SADC_SETTLE, SADC_CONV,
                SADC_LSB, SADC_DONE} sadc_state_t;
  sadc_state_t state;
  logic        sclk_d;
  logic        rise;
  logic        fall;
  logic [2:0]  cmd;
  logic [1:0]  cmd_cnt;
  logic        odd_sel;
  logic [7:0]  sar;
  logic [7:0]  trial;
  logic [7:0]  result;
  logic [3:0]  bit_cnt;
  logic [7:0]  vpos;
  logic [7:0]  vneg;
  logic [7:0]  neg_held;
  logic [8:0]  diff;
  logic        decide;
  logic        dout_oe_q;

  // Serial clock edges seen on the system clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) sclk_d <= 1'b0;
    else sclk_d <= pins.sclk;
  end
  assign rise = pins.sclk && !sclk_d && !pins.sel_n;
  assign fall = !pins.sclk && sclk_d && !pins.sel_n;

  // Input routing per mux assignment
  always_comb begin
    if (VARIANT == SADC_FIXED || !single_or_diff_sel) begin
      vpos = odd_sel ? analog_in_b : analog_in_a;
      vneg = odd_sel ? analog_in_a : analog_in_b;
    end else begin
      vpos = odd_sel ? analog_in_b : analog_in_a;
      vneg = 8'h00;
    end
  end

  // Comparator on held negative sample, decided at period end
  // Trial weight: count 1 tries the MSB, count 8 the LSB
  assign trial  = sar | (SADC_SAR_MSB >> (bit_cnt[2:0] - 3'd1));
  assign diff   = {1'b0, vpos} - {1'b0, neg_held} - {1'b0, trial};
  assign decide = (vpos > neg_held) && !diff[8];

  // Negative input sampled on each rise, half period before the fall that compares positive
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) neg_held <= '0;
    else if (pins.sel_n) neg_held <= '0;
    else if (rise) neg_held <= vneg;
  end

  // Sequencer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state              <= SADC_IDLE;
      cmd                <= '0;
      cmd_cnt            <= '0;
      odd_sel            <= 1'b0;
      single_or_diff_sel <= 1'b0;
      sar                <= SADC_RES_RST;
      result             <= SADC_RES_RST;
      bit_cnt            <= '0;
      busy               <= 1'b0;
    end else if (pins.sel_n) begin
      state              <= SADC_IDLE;
      cmd                <= '0;
      cmd_cnt            <= '0;
      odd_sel            <= 1'b0;
      single_or_diff_sel <= 1'b0;
      sar                <= SADC_RES_RST;
      result             <= SADC_RES_RST;
      bit_cnt            <= '0;
      busy               <= 1'b0;
    end else begin
      unique case (state)
        SADC_IDLE: begin
          busy <= 1'b1;
          if (VARIANT == SADC_FIXED) begin
            state <= SADC_SETTLE;
          end else begin
            state <= SADC_CMD;
          end
        end
        SADC_CMD: if (rise) begin
          cmd <= {cmd[1:0], pins.line};
          if (cmd_cnt != 2'd0 || pins.line) begin
            cmd_cnt <= cmd_cnt + 2'd1;
          end
          if (cmd_cnt == 2'd2) begin
            single_or_diff_sel <= cmd[0];
            odd_sel            <= pins.line;
            state              <= SADC_SETTLE;
          end
        end
        SADC_SETTLE: if (fall) begin
          state   <= SADC_CONV;
          bit_cnt <= 4'd1; // MSB decided on the next fall
        end
        SADC_CONV: if (fall && bit_cnt != 4'd0 || rise) begin
          if (rise) begin
            bit_cnt <= bit_cnt; // Sample phase
          end else begin
            sar <= decide ? trial : sar;
            result <= {result[6:0], decide};
            bit_cnt <= bit_cnt + 4'd1;
            if (bit_cnt == 4'd8) begin
              state   <= (VARIANT == SADC_MUXED) ? SADC_LSB : SADC_DONE;
              bit_cnt <= 4'd0;
            end
          end
        end else if (fall) begin
          bit_cnt <= 4'd1;
        end
        SADC_LSB: if (fall) begin
          result  <= {1'b0, result[7:1]};
          bit_cnt <= bit_cnt + 4'd1;
          if (bit_cnt == 4'd6) state <= SADC_DONE; // LSB already sent
        end
        SADC_DONE: busy <= 1'b0;
      endcase
    end
  end

  // Serial output pin driver
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pins.dout <= 1'b0;
      dout_oe_q <= 1'b0;
    end else if (pins.sel_n) begin
      pins.dout <= 1'b0;
      dout_oe_q <= 1'b0;
    end else if (fall && state != SADC_CMD) begin
      dout_oe_q <= 1'b1;
      if (state == SADC_CONV && bit_cnt != 4'd0) begin
        pins.dout <= decide;
      end else if (state == SADC_LSB) begin
        pins.dout <= result[1];
      end else begin
        pins.dout <= 1'b0;
      end
    end
  end
  assign pins.dout_oe = dout_oe_q;
endmodule

/* File: sadc_host.sv */
// Host end: drives select, clock and command; collects results
`timescale 1ns/10ps
module sadc_host
  import sadc_pkg::*;
#(
  parameter sadc_variant_t VARIANT = SADC_MUXED
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  sadc_if.host            pins,
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire logic [1:0] req_chan,
  output logic            res_valid,
  input  wire logic       res_ready,
  output logic [7:0]      res_data
);
  typedef enum {SADC_H_IDLE, SADC_H_RUN, SADC_H_PUSH} sadc_hstate_t;
  sadc_hstate_t state;
  logic [7:0]   half_cnt;
  logic [5:0]   fall_cnt;
  logic [2:0]   cmd;
  logic [7:0]   shreg;
  logic         f_ready;
  logic         sclk_q;

  // Result FIFO; full stalls new conversions
  sadc_fifo #(.WIDTH(SADC_RES_BITS), .DEPTH(SADC_FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (state == SADC_H_PUSH),
    .in_ready  (f_ready),
    .in_data   (shreg),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

  assign pins.sclk = sclk_q;

  // Transaction sequencer, gated serial clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state        <= SADC_H_IDLE;
      pins.sel_n   <= 1'b1;
      sclk_q       <= 1'b0;
      pins.cmd_out <= 1'b0;
      pins.cmd_oe  <= 1'b0;
      half_cnt     <= '0;
      fall_cnt     <= '0;
      cmd          <= '0;
      shreg        <= '0;
      req_ready    <= 1'b0;
    end else begin
      req_ready <= 1'b0;
      unique case (state)
        SADC_H_IDLE: if (req_valid && f_ready && !req_ready) begin
          req_ready  <= 1'b1;
          cmd        <= {1'b1, req_chan};
          pins.sel_n <= 1'b0;
          half_cnt   <= '0;
          fall_cnt   <= '0;
          sclk_q     <= 1'b0;
          if (VARIANT == SADC_MUXED) begin
            pins.cmd_oe  <= 1'b1;
            pins.cmd_out <= 1'b1;
          end
          state <= SADC_H_RUN;
        end
        SADC_H_RUN: begin
          half_cnt <= half_cnt + 8'd1;
          if (half_cnt == SADC_HALF_CNT - 8'd1) begin
            half_cnt <= '0;
            sclk_q   <= !sclk_q;
            if (sclk_q) begin
              fall_cnt <= fall_cnt + 6'd1;
              if (VARIANT == SADC_MUXED && fall_cnt < 6'd2) begin
                cmd          <= {cmd[1:0], 1'b0};
                pins.cmd_out <= cmd[1];
              end else if (VARIANT == SADC_MUXED) begin
                pins.cmd_oe <= 1'b0;
              end
            end else if (VARIANT == SADC_FIXED
                         && fall_cnt >= 6'd2 && fall_cnt <= 6'd9) begin
              shreg <= {shreg[6:0], pins.line};
            end else if (VARIANT == SADC_MUXED
                         && fall_cnt >= 6'd4 && fall_cnt <= 6'd11) begin
              shreg <= {shreg[6:0], pins.line};
            end
            if (sclk_q && fall_cnt == 6'd11) begin
              pins.sel_n <= 1'b1;
              state      <= SADC_H_PUSH;
            end
          end
        end
        SADC_H_PUSH: if (f_ready) state <= SADC_H_IDLE;
      endcase
    end
  end
endmodule

/* File: sadc_properties.sv */
// Timing checks on the serial pins between host and converter
`timescale 1ns/10ps
module sadc_properties
  import sadc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic cmd_out,
  input wire logic cmd_oe,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic line
);
  logic [7:0] rises;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Rising serial clock edges within the current frame
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rises <= 8'h00;
    end else if (sel_n) begin
      rises <= 8'h00;
    end else if ($rose(sclk) && rises != 8'hff) begin
      rises <= rises + 8'h01;
    end
  end
  property p_idle_hiz;
    sel_n && $past(sel_n) |-> !dout_oe && !cmd_oe && line;
  endproperty
  property p_no_clash;
    !(dout_oe && cmd_oe);
  endproperty
  property p_oe_on_fall;
    $rose(dout_oe) |-> !sclk && !sel_n;
  endproperty
  property p_dout_on_fall;
    dout_oe && $past(dout_oe) && $changed(dout) |-> !sclk;
  endproperty
  property p_cmd_stable;
    cmd_oe && $past(cmd_oe) && sclk && $past(sclk) |-> $stable(cmd_out);
  endproperty
  property p_start_one;
    rises == 8'h00 && $rose(sclk) && !sel_n |-> line;
  endproperty
  property p_hold_sel;
    $rose(sel_n) |-> rises >= 8'h09;
  endproperty
  property p_cmd_framed;
    cmd_oe |-> !sel_n;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz)
    else $error("serial line driven while deselected");
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the shared line");
  a_oe_on_fall: assert property (p_oe_on_fall)
    else $error("output enabled outside a low clock phase");
  a_dout_on_fall: assert property (p_dout_on_fall)
    else $error("result bit changed while serial clock high");
  a_cmd_stable: assert property (p_cmd_stable)
    else $error("command bit changed while serial clock high");
  a_start_one: assert property (p_start_one)
    else $error("first command bit is not a one");
  a_hold_sel: assert property (p_hold_sel)
    else $error("select released before result was read");
  a_cmd_framed: assert property (p_cmd_framed)
    else $error("command driven while deselected");
  c_frame: cover property ($fell(sel_n));
  c_result: cover property ($rose(dout_oe));
  c_done: cover property ($rose(sel_n));
endmodule

/* File: tb_serial_adc_conversion_interface.sv */
// Self-checking bench: host and converter joined by the serial pins
`timescale 1ns/10ps
module tb_serial_adc_conversion_interface
  import sadc_pkg::*;
;
  logic       clk_sys;
  logic       rst;
  logic       req_valid;
  logic       req_ready;
  logic [1:0] req_chan;
  logic       res_valid;
  logic       res_ready;
  logic [7:0] res_data;
  logic [7:0] analog_in_a;
  logic [7:0] analog_in_b;
  logic       single_or_diff_sel;
  logic       busy;
  logic       got;
  int         errors;
  int         tests_run;
  logic [7:0] exp_q[$];
  sadc_if pins ();
  sadc_host #(.VARIANT(SADC_MUXED)) sadc_host_i (.clk_sys(clk_sys),
    .rst(rst), .pins(pins), .req_valid(req_valid), .req_ready(req_ready),
    .req_chan(req_chan), .res_valid(res_valid), .res_ready(res_ready),
    .res_data(res_data));
  sadc_device #(.VARIANT(SADC_MUXED)) sadc_device_i (.clk_sys(clk_sys),
    .rst(rst), .pins(pins), .analog_in_a(analog_in_a),
    .analog_in_b(analog_in_b), .single_or_diff_sel(single_or_diff_sel),
    .busy(busy));
  sadc_properties sadc_properties_i (.clk_sys(clk_sys), .rst(rst),
    .sel_n(pins.sel_n), .sclk(pins.sclk), .cmd_out(pins.cmd_out),
    .cmd_oe(pins.cmd_oe), .dout(pins.dout), .dout_oe(pins.dout_oe),
    .line(pins.line));
  // 40 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // Code the digital comparator must settle on for a channel choice
  function automatic logic [7:0] exp_code(input logic [1:0] ch);
    logic [7:0] p;
    logic [7:0] n;
    p = ch[0] ? analog_in_b : analog_in_a;
    n = ch[0] ? analog_in_a : analog_in_b;
    if (ch[1]) return p;
    return (p > n) ? p - n : 8'h00;
  endfunction
  task automatic try_req(input logic [1:0] ch, input int lim);
    got = 1'b0;
    req_chan = ch;
    req_valid = 1'b1;
    for (int i = 0; i < lim && !got; i++) begin
      @(posedge clk_sys);
      #1;
      got = (req_ready === 1'b1);
    end
    req_valid = 1'b0;
  endtask
  task automatic req(input logic [1:0] ch);
    try_req(ch, 8000);
    chk(got, "request not taken");
    if (!got) wrap_up();
    exp_q.push_back(exp_code(ch));
  endtask
  task automatic take();
    logic [7:0] e;
    e = exp_q.pop_front();
    for (int i = 0; i < 8000 && res_valid !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(res_valid === 1'b1, "no result");
    if (res_valid !== 1'b1) wrap_up();
    chk(res_data === e, "wrong result code");
    res_ready = 1'b1;
    @(posedge clk_sys);
    #1;
    res_ready = 1'b0;
  endtask
  task automatic t_modes();
    analog_in_a = 8'hc3;
    analog_in_b = 8'h5a;
    for (int c = 0; c < 4; c++) begin
      req(c[1:0]);
      repeat (800) @(posedge clk_sys);
      #1;
      chk(single_or_diff_sel === c[1], "mode bit not latched");
      take();
    end
    repeat (4) @(posedge clk_sys);
    #1;
    chk(busy === 1'b0, "busy after result");
    chk(pins.dout_oe === 1'b0, "output left on");
    $display("test modes done");
  endtask
  task automatic t_zero();
    analog_in_a = 8'h5a;
    analog_in_b = 8'hc3;
    req(2'h0);
    take();
    req(2'h1);
    take();
    analog_in_b = 8'h5a;
    req(2'h0);
    take();
    analog_in_a = 8'hff;
    analog_in_b = 8'h00;
    req(2'h2);
    req(2'h3);
    take();
    take();
    $display("test zero done");
  endtask
  task automatic t_fifo();
    analog_in_a = 8'h81;
    analog_in_b = 8'h7e;
    for (int k = 0; k < 16; k++) begin
      req(k[1:0]);
    end
    try_req(2'h2, 6000);
    chk(!got, "request taken with buffer full");
    for (int k = 0; k < 16; k++) begin
      take();
    end
    chk(res_valid === 1'b0, "buffer not empty");
    $display("test fifo done");
  endtask
  // Reset, scenarios, verdict
  initial begin
    errors = 0;
    tests_run = 0;
    rst = 1'b1;
    req_valid = 1'b0;
    req_chan = 2'h0;
    res_ready = 1'b0;
    analog_in_a = 8'h00;
    analog_in_b = 8'h00;
    repeat (8) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_modes();
    t_zero();
    t_fifo();
    wrap_up();
  end
endmodule
